// File: rtl/iee_front_end.sv
// serial two-wire slave front end with 8192 byte array and page programming
// assumes SCL_LINK is the master's serial clock, SDA pins resolved outside,
// and pad pull-downs on the strap and write-protect pins
`timescale 1ns/1ps
module iee_front_end
  import iee_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  input  wire logic CLK,
  input  wire logic RESET_N,
  input  wire logic SCL_LINK,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE,
  input  wire logic STRAP_SEL_BIT0,
  input  wire logic STRAP_SEL_BIT1,
  input  wire logic STRAP_SEL_BIT2,
  input  wire logic WRITE_PROTECT_IN,
  output logic      WRITE_BUSY
);
  localparam int WC_W = $clog2(WRITE_CYCLES_P + 1);

  iee_link_state_type   state_reg;
  iee_commit_state_type cm_state_reg;
  logic [3:0]            cnt_reg;
  logic [7:0]            shift_reg;
  logic [7:0]            tx_reg;
  logic [7:0]            byte_now;
  logic [ADDR_W-1:0]     addr_reg;
  logic [ADDR_W-1:PAGE_W] wr_page_reg;
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [7:0]            page_buf [PAGE_BYTES];
  logic                  ack_reg;
  logic                  rw_reg;
  logic                  sda_oe_reg;
  logic                  sda_out_reg;
  logic                  start_tog_reg;
  logic                  stop_tog_reg;
  logic                  start_seen_reg;
  logic                  stop_seen_reg;
  logic                  new_frame;
  logic                  stop_hit;
  logic                  byte_done;
  logic                  sel_match;
  logic [2:0]            strap_meta_reg;
  logic [2:0]            strap_reg;
  logic                  busy_meta_reg;
  logic                  busy_s_reg;
  logic [7:0]            rd_data;
  logic [2:0]            stop_sync_reg;
  logic [1:0]            wp_sync_reg;
  logic                  stop_evt;
  logic                  busy_reg;
  logic [PAGE_W-1:0]     off_reg;
  logic [WC_W-1:0]       wait_reg;
  logic                  mem_wr_en;
  logic                  prot_hit;

  // start and stop are data edges while the clock is high; only the data pin
  // edges can see them, so they toggle flags the link clock compares later
  always_ff @(negedge SDA_IN or negedge RESET_N) begin
    if (!RESET_N) begin
      start_tog_reg <= 1'b0;
    end else if (SCL_LINK) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  always_ff @(posedge SDA_IN or negedge RESET_N) begin
    if (!RESET_N) begin
      stop_tog_reg <= 1'b0;
    end else if (SCL_LINK) begin
      stop_tog_reg <= ~stop_tog_reg;
    end
  end

  // the toggles settle half a clock period before the next rising edge,
  // so the link clock reads them without a synchroniser
  assign new_frame = start_tog_reg != start_seen_reg;
  assign stop_hit  = stop_tog_reg != stop_seen_reg;
  assign byte_now  = {shift_reg[6:0], SDA_IN};
  assign byte_done = !new_frame && !stop_hit && state_reg != ST_IDLE &&
                     cnt_reg == LAST_BIT;
  assign sel_match = byte_now[7:4] == TYPE_ID &&
                     byte_now[3:1] == strap_reg &&
                     !busy_s_reg;

  always_ff @(posedge SCL_LINK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_meta_reg <= 3'h0;
      strap_reg      <= 3'h0;
      busy_meta_reg  <= 1'b0;
      busy_s_reg     <= 1'b0;
    end else begin
      // floating straps arrive as zero through the pad pull-downs
      strap_meta_reg <= {STRAP_SEL_BIT2, STRAP_SEL_BIT1,
                         STRAP_SEL_BIT0};
      strap_reg      <= strap_meta_reg;
      busy_meta_reg  <= busy_reg;
      busy_s_reg     <= busy_meta_reg;
    end
  end

  // byte engine, clocked only by the serial clock
  always_ff @(posedge SCL_LINK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= 4'h0;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      ack_reg        <= 1'b0;
      rw_reg         <= 1'b0;
      addr_reg       <= '0;
      wr_page_reg    <= '0;
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
    end else begin
      start_seen_reg <= start_tog_reg;
      stop_seen_reg  <= stop_tog_reg;
      if (new_frame) begin
        state_reg <= ST_SELECT;
        cnt_reg   <= 4'h1;
        shift_reg <= {7'h00, SDA_IN};
        ack_reg   <= 1'b0;
      end else if (stop_hit || state_reg == ST_IDLE) begin
        state_reg <= ST_IDLE;
        cnt_reg   <= 4'h0;
        ack_reg   <= 1'b0;
      end else if (cnt_reg != ACK_SLOT) begin
        shift_reg <= byte_now;
        cnt_reg   <= cnt_reg + 4'h1;
        if (cnt_reg == LAST_BIT) begin
          unique case (state_reg)
            ST_SELECT: begin
              ack_reg <= sel_match;
              rw_reg  <= byte_now[0];
            end
            ST_ADDR_HI: begin
              ack_reg                <= 1'b1;
              addr_reg[ADDR_W-1:8]   <= byte_now[ADDR_W-9:0];
            end
            ST_ADDR_LO: begin
              ack_reg       <= 1'b1;
              addr_reg[7:0] <= byte_now;
              wr_page_reg   <= {addr_reg[ADDR_W-1:8], byte_now[7:PAGE_W]};
            end
            ST_WDATA: begin
              ack_reg                <= 1'b1;
              // page writes roll over inside the page
              addr_reg[PAGE_W-1:0]   <= addr_reg[PAGE_W-1:0] + 1'b1;
            end
            default: ack_reg <= 1'b0;
          endcase
        end
      end else begin
        cnt_reg <= 4'h0;
        ack_reg <= 1'b0;
        unique case (state_reg)
          ST_SELECT: begin
            if (!ack_reg) begin
              state_reg <= ST_IDLE;
            end else if (rw_reg) begin
              state_reg <= ST_RDATA;
              tx_reg    <= rd_data;
              addr_reg  <= addr_reg + 1'b1;
            end else begin
              state_reg <= ST_ADDR_HI;
            end
          end
          ST_ADDR_HI: state_reg <= ST_ADDR_LO;
          ST_ADDR_LO: state_reg <= ST_WDATA;
          ST_WDATA:   state_reg <= ST_WDATA;
          ST_RDATA: begin
            if (!SDA_IN) begin
              tx_reg   <= rd_data;
              addr_reg <= addr_reg + 1'b1;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge SCL_LINK) begin
    if (byte_done && state_reg == ST_WDATA) begin
      page_buf[addr_reg[PAGE_W-1:0]] <= byte_now;
    end
  end

  always_ff @(posedge SCL_LINK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_reg <= '0;
    end else if (byte_done && state_reg == ST_ADDR_LO) begin
      mask_reg <= '0;
    end else if (byte_done && state_reg == ST_WDATA) begin
      mask_reg[addr_reg[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // data changes only while the clock is low
  always_ff @(negedge SCL_LINK or negedge RESET_N) begin
    if (!RESET_N) begin
      sda_oe_reg <= 1'b0;
    end else if (cnt_reg == ACK_SLOT) begin
      sda_oe_reg <= ack_reg;
    end else if (state_reg == ST_RDATA) begin
      sda_oe_reg <= ~tx_reg[3'(LAST_BIT - cnt_reg)];
    end else begin
      sda_oe_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
    end
  end

  assign SDA_OUT = sda_out_reg;
  assign SDA_OE  = sda_oe_reg;

  // system clock side: stop toggle and write protect cross by two flops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stop_sync_reg <= 3'h0;
      wp_sync_reg   <= 2'h0;
    end else begin
      stop_sync_reg <= {stop_sync_reg[1:0], stop_tog_reg};
      // a floating write-protect pin reads low through its pull-down
      wp_sync_reg   <= {wp_sync_reg[0], WRITE_PROTECT_IN};
    end
  end

  assign stop_evt = stop_sync_reg[2] ^ stop_sync_reg[1];
  assign prot_hit = wp_sync_reg[1] &&
                    wr_page_reg[ADDR_W-1 -: 2] == PROT_QUARTER;
  // page buffer and mask stand still after the stop, so reading them here
  // is safe; a master that restarts within a few clocks can race the busy
  assign mem_wr_en = cm_state_reg == CM_COPY && mask_reg[off_reg] &&
                     !prot_hit;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cm_state_reg <= CM_IDLE;
      busy_reg     <= 1'b0;
      off_reg      <= '0;
      wait_reg     <= '0;
    end else begin
      unique case (cm_state_reg)
        CM_IDLE: begin
          if (stop_evt && mask_reg != '0) begin
            cm_state_reg <= CM_COPY;
            busy_reg     <= 1'b1;
            off_reg      <= '0;
          end
        end
        CM_COPY: begin
          off_reg <= off_reg + 1'b1;
          if (off_reg == PAGE_W'(PAGE_BYTES - 1)) begin
            cm_state_reg <= CM_WAIT;
            wait_reg     <= WC_W'(WRITE_CYCLES_P - 1);
          end
        end
        CM_WAIT: begin
          if (wait_reg == '0) begin
            cm_state_reg <= CM_IDLE;
            busy_reg     <= 1'b0;
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        default: cm_state_reg <= CM_IDLE;
      endcase
    end
  end

  assign WRITE_BUSY = busy_reg;

  iee_mem u_mem (
    .clk     (CLK),
    .wr_en   (mem_wr_en),
    .wr_addr ({wr_page_reg, off_reg}),
    .wr_data (page_buf[off_reg]),
    .rd_addr (addr_reg),
    .rd_data (rd_data)
  );
endmodule

// File: rtl/iee_mem.sv
// byte array of the memory: written on the system clock, read without a clock
// assumes writes only happen while the link side refuses new frames
`timescale 1ns/1ps
module iee_mem
  import iee_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  parameter int AW    = ADDR_W,
  parameter int DW    = DATA_W
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] array_mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      array_mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = array_mem[rd_addr];
endmodule

// File: rtl/iee_pkg.sv
// constants, state types and layout of the serial memory slave front end
// assumes a 20 MHz system clock and a bus master that makes the serial clock
// Functional notes
// - memory holds 8192 locations of eight bits, reachable serially
// - select byte is ours only when its upper four bits equal the type code
// - each transfer opens with Start, select byte with direction, then ack
// - after each byte the master writes, device pulls data low in ninth bit
// - data line is open drain: pulled low or released, never driven high
// - every received or sent data bit is timed by the serial clock alone
// - select bits b3..b1 must equal the three chip-select strap inputs
// - an unconnected chip-select strap counts as logic zero
// - write protect high refuses writes to upper quarter; low allows them
// - an unconnected write-protect input counts as low, writes allowed
// - select byte bit zero is direction: one reads, zero writes
// - Stop at end of a write command launches the internal programming cycle
// - data line is sampled on each rising serial clock edge while receiving
// - select mismatch: no acknowledge, release bus, idle until next Start
package iee_pkg;
  localparam int          MEM_DEPTH     = 8192;
  localparam int          ADDR_W        = 13;
  localparam int          DATA_W        = 8;
  localparam int          PAGE_BYTES    = 32;
  localparam int          PAGE_W        = 5;
  // type code value is arbitrary
  localparam logic [3:0]  TYPE_ID       = 4'h5;
  localparam logic [1:0]  PROT_QUARTER  = 2'h3;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;
  localparam longint      CLK_HZ        = 64'd20_000_000;
  localparam longint      WRITE_TIME_NS = 64'd5_000_000;
  localparam int          WRITE_CYCLES  =
    int'((WRITE_TIME_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);

  typedef enum logic [2:0] {
    ST_IDLE, ST_SELECT, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA
  } iee_link_state_type;

  typedef enum logic [1:0] {
    CM_IDLE, CM_COPY, CM_WAIT
  } iee_commit_state_type;
endpackage

// File: tb/iee_front_end_checker.sv
// checker of the serial memory front end, bound to its top module
// assumes the master moves the data line while the serial clock is high only for Start and Stop
`timescale 1ns/1ps
module iee_front_end_checker
  import iee_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SCL_LINK,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic WRITE_BUSY
);
  logic oe_rise_reg;
  int   busy_cnt_reg;

  always_ff @(posedge SCL_LINK or negedge RESET_N) begin
    if (!RESET_N) oe_rise_reg <= 1'b0;
    else oe_rise_reg <= SDA_OE;
  end

  // copy plus wait, with slack for the synchronisers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) busy_cnt_reg <= 0;
    else if (WRITE_BUSY) busy_cnt_reg <= busy_cnt_reg + 1;
    else busy_cnt_reg <= 0;
  end

  sequence busy_launch_s;
    $rose(WRITE_BUSY);
  endsequence

  out_never_high_a: assert property (@(posedge CLK)
    disable iff (!RESET_N) SDA_OUT == 1'b0)
    else $error("data line driven high");
  oe_pulls_low_a: assert property (@(posedge SCL_LINK)
    disable iff (!RESET_N) SDA_OE |-> SDA_OUT == 1'b0)
    else $error("enabled data line not low");
  oe_scl_timed_a: assert property (@(negedge SCL_LINK)
    disable iff (!RESET_N) SDA_OE == oe_rise_reg)
    else $error("data drive moved while clock high");
  busy_holds_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    busy_launch_s |-> WRITE_BUSY [*8]) else $error("busy pulse too short");
  busy_bounded_a: assert property (@(posedge CLK)
    disable iff (!RESET_N) busy_cnt_reg <= PAGE_BYTES + WRITE_CYCLES_P + 4)
    else $error("programming too long");
  busy_on_stop_a: assert property (@(posedge CLK)
    disable iff (!RESET_N) busy_launch_s |-> SCL_LINK && SDA_IN)
    else $error("busy without stop");
  busy_no_ack_a: assert property (@(posedge SCL_LINK)
    disable iff (!RESET_N) WRITE_BUSY |-> !SDA_OE)
    else $error("bus driven while programming");
  reset_quiet_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(RESET_N) |-> !WRITE_BUSY && !SDA_OE)
    else $error("outputs active after reset");
endmodule

bind iee_front_end iee_front_end_checker #(
  .WRITE_CYCLES_P(WRITE_CYCLES_P)
) i_iee_front_end_checker (
  .CLK       (CLK),
  .RESET_N   (RESET_N),
  .SCL_LINK  (SCL_LINK),
  .SDA_IN    (SDA_IN),
  .SDA_OUT   (SDA_OUT),
  .SDA_OE    (SDA_OE),
  .WRITE_BUSY(WRITE_BUSY)
);

// File: tb/iee_front_end_test.sv
// self-checking bench of the serial memory front end
// assumes the master model drives all link traffic
`timescale 1ns/1ps
module iee_front_end_test
  import iee_pkg::*;
;
  logic       clk;
  logic       reset_n;
  logic [2:0] strap;
  logic       wp;
  logic       scl;
  logic       m_low;
  logic       sda_oe;
  logic       sda_out;
  logic       busy;
  wire        sda = ~m_low & ~(sda_oe & ~sda_out);
  int         error_cnt = 0;
  int         n_tests = 0;

  iee_front_end #(
    .WRITE_CYCLES_P(20)
  ) i_iee_front_end (
    .CLK             (clk),
    .RESET_N         (reset_n),
    .SCL_LINK        (scl),
    .SDA_IN          (sda),
    .SDA_OUT         (sda_out),
    .SDA_OE          (sda_oe),
    .STRAP_SEL_BIT0  (strap[0]),
    .STRAP_SEL_BIT1  (strap[1]),
    .STRAP_SEL_BIT2  (strap[2]),
    .WRITE_PROTECT_IN(wp),
    .WRITE_BUSY      (busy)
  );

  iee_master_model i_iee_master_model (
    .scl    (scl),
    .sda_low(m_low),
    .sda    (sda)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic pins(input logic [2:0] s, input logic w);
    @(posedge clk);
    #1;
    strap = s;
    wp = w;
  endtask

  task automatic probe(input logic [7:0] s, input logic exp_nak);
    logic n;
    i_iee_master_model.start();
    i_iee_master_model.send(s, n);
    i_iee_master_model.stop();
    chk("select nak", {7'h0, n}, {7'h0, exp_nak});
  endtask

  task automatic addr_frame(input logic [12:0] a, output logic nak);
    logic n1;
    logic n2;
    i_iee_master_model.start();
    i_iee_master_model.send({TYPE_ID, strap, 1'b0}, nak);
    i_iee_master_model.send({3'h0, a[12:8]}, n1);
    i_iee_master_model.send(a[7:0], n2);
    nak = nak | n1 | n2;
  endtask

  task automatic mem_wr(input logic [12:0] a, input logic [7:0] d);
    logic n;
    logic n2;
    addr_frame(a, n);
    i_iee_master_model.send(d, n2);
    i_iee_master_model.stop();
    chk("write nak", {7'h0, n | n2}, 8'h0);
    repeat (6) @(posedge clk);
    #1;
    if (!(wp && a[12:11] == PROT_QUARTER)) begin
      chk("busy", {7'h0, busy}, 8'h1);
    end
    if (busy) probe({TYPE_ID, strap, 1'b0}, 1'b1);
    for (int i = 0; i < 200 && busy; i++) @(posedge clk);
    chk("busy end", {7'h0, busy}, 8'h0);
  endtask

  task automatic mem_rd(input logic [12:0] a, input logic [7:0] exp);
    logic       n;
    logic       n2;
    logic [7:0] d;
    addr_frame(a, n);
    i_iee_master_model.start();
    i_iee_master_model.send({TYPE_ID, strap, 1'b1}, n2);
    i_iee_master_model.recv(1'b1, d);
    i_iee_master_model.stop();
    chk("read nak", {7'h0, n | n2}, 8'h0);
    chk("read data", d, exp);
  endtask

  // sequential read: master acks the first byte, the address runs on
  task automatic seq_rd(input logic [12:0] a, input logic [7:0] e0, e1);
    logic       n;
    logic       n2;
    logic [7:0] d0;
    logic [7:0] d1;
    addr_frame(a, n);
    i_iee_master_model.start();
    i_iee_master_model.send({TYPE_ID, strap, 1'b1}, n2);
    i_iee_master_model.recv(1'b0, d0);
    i_iee_master_model.recv(1'b1, d1);
    i_iee_master_model.stop();
    chk("seq nak", {7'h0, n | n2}, 8'h0);
    chk("seq data 0", d0, e0);
    chk("seq data 1", d1, e1);
  endtask

  initial begin
    reset_n = 1'b0;
    strap = 3'h5;
    wp = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("oe in reset", {7'h0, sda_oe}, 8'h0);
    chk("out in reset", {7'h0, sda_out}, 8'h0);
    reset_n = 1'b1;
    repeat (2) @(posedge clk);
    mem_wr(13'h0000, 8'h3c);
    mem_rd(13'h0000, 8'h3c);
    for (int i = 0; i < 3; i++) begin
      probe({TYPE_ID, strap ^ (3'h1 << i), 1'b0}, 1'b1);
    end
    probe({~TYPE_ID, strap, 1'b0}, 1'b1);
    probe({TYPE_ID, strap, 1'b0}, 1'b0);
    mem_wr(13'h1800, 8'ha5);
    pins(3'h5, 1'b1);
    mem_wr(13'h1800, 8'h11);
    mem_wr(13'h17ff, 8'h22);
    mem_rd(13'h1800, 8'ha5);
    mem_rd(13'h17ff, 8'h22);
    seq_rd(13'h17ff, 8'h22, 8'ha5);
    chk("out low", {7'h0, sda_out}, 8'h0);
    pins(3'h0, 1'b0);
    mem_wr(13'h1fff, 8'h77);
    mem_rd(13'h1fff, 8'h77);
    report_and_stop();
  end

  // roughly twenty times the expected run
  initial begin
    #500_000;
    error_cnt++;
    report_and_stop();
  end
endmodule

// File: tb/iee_master_model.sv
// bus master model: makes the serial clock inside frames and pulls data low
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
module iee_master_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam realtime HALF = 7.5;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // data moves 2 ns into the low phase to keep clear of start detection
  task automatic bit_io(input logic b, output logic r);
    #2 sda_low = ~b;
    #(HALF - 2) scl = 1'b1;
    r = sda;
    #HALF scl = 1'b0;
  endtask

  task automatic start;
    #2 sda_low = 1'b0;
    #(HALF - 2) scl = 1'b1;
    #HALF sda_low = 1'b1;
    #HALF scl = 1'b0;
  endtask

  // clock is left standing high after a stop
  task automatic stop;
    #2 sda_low = 1'b1;
    #(HALF - 2) scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask

  task automatic send(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask

  task automatic recv(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nak, r);
  endtask
endmodule
